//--- verilog/dmap_top.v
// dmap_top: drive i/o function mapper with its axi4-lite register file
// assumes one clock, pins already synchronous to it, and a master that keeps the axi4-lite rules
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dmap_consts.vh"

module dmap_top #(
  parameter N_IN_FUNC  = 32,
  parameter N_IN_PIN   = 12,
  parameter N_IN_FIX   = 3,
  parameter N_OUT_FUNC = 24,
  parameter N_OUT_PIN  = 10,
  parameter N_OUT_FIX  = 1,
  parameter N_USER     = 9
) (
  input  wire                  ref_clk_in,
  input  wire                  reset_n_in,
  // axi4-lite slave
  input  wire [11:0]           s_axi_awaddr_in,
  input  wire                  s_axi_awvalid_in,
  output reg                   s_axi_awready_out,
  input  wire [31:0]           s_axi_wdata_in,
  input  wire [3:0]            s_axi_wstrb_in,
  input  wire                  s_axi_wvalid_in,
  output reg                   s_axi_wready_out,
  output reg  [1:0]            s_axi_bresp_out,
  output reg                   s_axi_bvalid_out,
  input  wire                  s_axi_bready_in,
  input  wire [11:0]           s_axi_araddr_in,
  input  wire                  s_axi_arvalid_in,
  output reg                   s_axi_arready_out,
  output reg  [31:0]           s_axi_rdata_out,
  output reg  [1:0]            s_axi_rresp_out,
  output reg                   s_axi_rvalid_out,
  input  wire                  s_axi_rready_in,
  // control connector pins and the drive's functions
  input  wire [N_IN_PIN-1:0]   in_pin_in,
  input  wire [N_OUT_FUNC-1:0] out_func_in,
  output reg  [N_IN_FUNC-1:0]  in_func_out,
  output reg  [N_OUT_PIN-1:0]  out_pin_out,
  output reg                   nv_save_out
);

  localparam SEL_W   = `DMAP_SEL_W;
  localparam N_IN_A  = N_IN_PIN - N_IN_FIX;
  localparam N_OUT_A = N_OUT_PIN - N_OUT_FIX;

  // configuration storage
  reg  [SEL_W-1:0]         in_sel [0:N_IN_A-1];
  reg  [SEL_W-1:0]         out_sel [0:N_OUT_A-1];
  reg  [N_IN_PIN-1:0]      in_lvl;
  reg  [N_OUT_PIN-1:0]     out_lvl;
  reg  [N_IN_FUNC-1:0]     force_on;
  reg  [N_USER-1:0]        user_out;
  // status captured every cycle
  reg  [N_IN_PIN-1:0]      in_pin_on;
  reg  [N_OUT_PIN-1:0]     out_pin_on;
  // write channel holding registers
  reg  [11:0]              wr_addr;
  reg  [31:0]              wr_data;
  reg  [3:0]               wr_strb;
  // combinational helpers
  wire [N_IN_A*SEL_W-1:0]  in_sel_flat;
  wire [N_OUT_A*SEL_W-1:0] out_sel_flat;
  wire [N_IN_PIN-1:0]      in_on_w;
  wire [N_IN_FUNC-1:0]     in_func_w;
  wire [N_OUT_PIN-1:0]     out_on_w;
  wire [N_OUT_PIN-1:0]     out_lvl_w;
  wire [N_OUT_FUNC-1:0]    out_func_mix;
  wire                     do_write;
  wire [3:0]               wr_idx;
  wire [3:0]               rd_idx;
  wire                     wr_in_cfg;
  wire                     wr_out_cfg;
  wire                     rd_in_cfg;
  wire                     rd_out_cfg;
  reg  [31:0]              rd_word;
  reg                      rd_hit;
  reg                      wr_hit;
  integer                  i;

  genvar g;

  // flatten the select arrays for the routing modules
  generate
    for (g = 0; g < N_IN_A; g = g + 1)
    begin : g_in_flat
      assign in_sel_flat[g*SEL_W +: SEL_W] = in_sel[g];
    end
    for (g = 0; g < N_OUT_A; g = g + 1)
    begin : g_out_flat
      assign out_sel_flat[g*SEL_W +: SEL_W] = out_sel[g];
    end
  endgenerate

  dmap_in_route #(
    .N_FUNC (N_IN_FUNC),
    .N_PIN  (N_IN_PIN),
    .N_FIX  (N_IN_FIX),
    .SEL_W  (SEL_W),
    .LAUNCH (`DMAP_FN_TABLE_LAUNCH)
  ) u_in_route (
    .pin_in      (in_pin_in),
    .level_in    (in_lvl),
    .sel_flat_in (in_sel_flat),
    .force_in    (force_on),
    .pin_on_out  (in_on_w),
    .func_out    (in_func_w)
  );

  // user output functions come from the software-held state, the rest from the drive
  assign out_func_mix = {user_out, out_func_in[`DMAP_OFN_USER_BASE-1:0]};

  dmap_out_route #(
    .N_FUNC (N_OUT_FUNC),
    .N_PIN  (N_OUT_PIN),
    .N_FIX  (N_OUT_FIX),
    .SEL_W  (SEL_W)
  ) u_out_route (
    .func_in       (out_func_mix),
    .level_in      (out_lvl),
    .sel_flat_in   (out_sel_flat),
    .pin_on_out    (out_on_w),
    .pin_level_out (out_lvl_w)
  );

  // every output leaves from a flop; one cycle of latency from pin to function
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      in_func_out <= {N_IN_FUNC{1'b0}};
      out_pin_out <= {N_OUT_PIN{1'b0}};
      in_pin_on   <= {N_IN_PIN{1'b0}};
      out_pin_on  <= {N_OUT_PIN{1'b0}};
    end
    else
    begin
      in_func_out <= in_func_w;
      out_pin_out <= out_lvl_w;
      in_pin_on   <= in_on_w;
      out_pin_on  <= out_on_w;
    end
  end

  // write decode: a write happens once both address and data are held
  assign do_write   = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
  assign wr_idx     = wr_addr[5:2];
  assign rd_idx     = s_axi_araddr_in[5:2];
  assign wr_in_cfg  = ({wr_addr[11:6], 6'h00} == `DMAP_IN_CFG_BASE) && (wr_idx < N_IN_PIN);
  assign wr_out_cfg = ({wr_addr[11:6], 6'h00} == `DMAP_OUT_CFG_BASE) && (wr_idx < N_OUT_PIN);
  assign rd_in_cfg  = ({s_axi_araddr_in[11:6], 6'h00} == `DMAP_IN_CFG_BASE) && (rd_idx < N_IN_PIN);
  assign rd_out_cfg = ({s_axi_araddr_in[11:6], 6'h00} == `DMAP_OUT_CFG_BASE) && (rd_idx < N_OUT_PIN);

  // decide whether the held write address is mapped
  always @*
  begin
    wr_hit = 1'b0;
    if (wr_in_cfg || wr_out_cfg)
      wr_hit = 1'b1;
    else
      case (wr_addr)
        `DMAP_FORCE_ADDR,
        `DMAP_TOGGLE_ADDR,
        `DMAP_USER_OUT_ADDR,
        `DMAP_IN_PIN_ADDR,
        `DMAP_OUT_PIN_ADDR,
        `DMAP_FUNC_ADDR,
        `DMAP_NV_CTRL_ADDR: wr_hit = 1'b1;
        default:            wr_hit = 1'b0;
      endcase
  end

  // write address and data channels, taken in either order
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `DMAP_RESP_OKAY;
      wr_addr           <= 12'h000;
      wr_data           <= 32'h0000_0000;
      wr_strb           <= 4'h0;
    end
    else
    begin
      if (s_axi_awready_out && s_axi_awvalid_in)
      begin
        wr_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wready_out && s_axi_wvalid_in)
      begin
        wr_data          <= s_axi_wdata_in;
        wr_strb          <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `DMAP_RESP_OKAY : `DMAP_RESP_DECERR;
      end
      // readies return only after the response is taken, so one write at a time
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // register file updates; new settings act on the very next cycle
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (i = 0; i < N_IN_A; i = i + 1)
        in_sel[i] <= `DMAP_SEL_NONE;
      for (i = 0; i < N_OUT_A; i = i + 1)
        out_sel[i] <= `DMAP_SEL_NONE;
      in_lvl      <= {N_IN_PIN{`DMAP_LVL_RESET}};
      out_lvl     <= {N_OUT_PIN{`DMAP_LVL_RESET}};
      force_on    <= `DMAP_FORCE_RESET;
      user_out    <= {N_USER{1'b0}};
      nv_save_out <= 1'b0;
    end
    else
    begin
      nv_save_out <= 1'b0;
      if (do_write)
      begin
        if (wr_in_cfg)
        begin
          // fixed pins keep their function; only the level can be written
          if (wr_strb[0] && (wr_idx >= N_IN_FIX))
            in_sel[wr_idx - N_IN_FIX] <= wr_data[`DMAP_SEL_LSB +: SEL_W];
          if (wr_strb[1])
            in_lvl[wr_idx] <= wr_data[`DMAP_LVL_BIT];
        end
        if (wr_out_cfg)
        begin
          if (wr_strb[0] && (wr_idx >= N_OUT_FIX))
            out_sel[wr_idx - N_OUT_FIX] <= wr_data[`DMAP_SEL_LSB +: SEL_W];
          if (wr_strb[1])
            out_lvl[wr_idx] <= wr_data[`DMAP_LVL_BIT];
        end
        if (wr_addr == `DMAP_FORCE_ADDR)
        begin
          // byte lanes honoured; writing zero releases a forced function
          for (i = 0; i < N_IN_FUNC; i = i + 1)
            if (wr_strb[i/8])
              force_on[i] <= wr_data[i];
        end
        if (wr_addr == `DMAP_TOGGLE_ADDR)
        begin
          // a one flips the user output, a zero leaves it alone
          for (i = 0; i < N_USER; i = i + 1)
            if (wr_strb[i/8] && wr_data[i])
              user_out[i] <= ~user_out[i];
        end
        if ((wr_addr == `DMAP_NV_CTRL_ADDR) && wr_strb[0] && wr_data[`DMAP_NV_SAVE_BIT])
          nv_save_out <= 1'b1;
      end
    end
  end

  // read mux; reserved bits and unmapped words read as zero
  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (rd_in_cfg)
    begin
      if (rd_idx < N_IN_FIX)
        rd_word[`DMAP_SEL_LSB +: SEL_W] = {2'b00, rd_idx} + 6'h01;
      else
        rd_word[`DMAP_SEL_LSB +: SEL_W] = in_sel[rd_idx - N_IN_FIX];
      rd_word[`DMAP_LVL_BIT] = in_lvl[rd_idx];
    end
    else if (rd_out_cfg)
    begin
      if (rd_idx < N_OUT_FIX)
        rd_word[`DMAP_SEL_LSB +: SEL_W] = {2'b00, rd_idx} + 6'h01;
      else
        rd_word[`DMAP_SEL_LSB +: SEL_W] = out_sel[rd_idx - N_OUT_FIX];
      rd_word[`DMAP_LVL_BIT] = out_lvl[rd_idx];
    end
    else
      case (s_axi_araddr_in)
        `DMAP_FORCE_ADDR:    rd_word[N_IN_FUNC-1:0] = force_on;
        `DMAP_TOGGLE_ADDR:   rd_word = 32'h0000_0000;
        `DMAP_USER_OUT_ADDR: rd_word[N_USER-1:0] = user_out;
        `DMAP_IN_PIN_ADDR:   rd_word[N_IN_PIN-1:0] = in_pin_on;
        `DMAP_OUT_PIN_ADDR:  rd_word[N_OUT_PIN-1:0] = out_pin_on;
        `DMAP_FUNC_ADDR:     rd_word[N_IN_FUNC-1:0] = in_func_out;
        `DMAP_NV_CTRL_ADDR:  rd_word = 32'h0000_0000;
        default:             rd_hit = 1'b0;
      endcase
  end

  // read channel: answer one cycle after the address is taken
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `DMAP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arready_out && s_axi_arvalid_in)
      begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_word;
        s_axi_rresp_out   <= rd_hit ? `DMAP_RESP_OKAY : `DMAP_RESP_DECERR;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
      begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

endmodule // dmap_top

`default_nettype wire

//--- verilog/dmap_consts.vh
// constants of the drive i/o function mapper: register offsets, fields, reset values
// assumes a 12-bit byte address from an axi4-lite slave with 32-bit data
`ifndef DMAP_CONSTS_VH
`define DMAP_CONSTS_VH

// register byte offsets
`define DMAP_IN_CFG_BASE    12'h000
`define DMAP_OUT_CFG_BASE   12'h040
`define DMAP_FORCE_ADDR     12'h080
`define DMAP_TOGGLE_ADDR    12'h084
`define DMAP_USER_OUT_ADDR  12'h088
`define DMAP_IN_PIN_ADDR    12'h08C
`define DMAP_OUT_PIN_ADDR   12'h090
`define DMAP_FUNC_ADDR      12'h094
`define DMAP_NV_CTRL_ADDR   12'h098

// configuration word fields: function select in [5:0], active level in [8]
`define DMAP_SEL_LSB        0
`define DMAP_SEL_W          6
`define DMAP_LVL_BIT        8
`define DMAP_NV_SAVE_BIT    0

// reset values: pin unmapped, low active, nothing forced
`define DMAP_SEL_NONE       6'h00
`define DMAP_LVL_RESET      1'b0
`define DMAP_FORCE_RESET    32'h0000_0000

// function indexes
`define DMAP_FN_LIMIT_POS   0
`define DMAP_FN_LIMIT_NEG   1
`define DMAP_FN_HOME        2
`define DMAP_FN_TABLE_LAUNCH 12
`define DMAP_OFN_COMPARE    0
`define DMAP_OFN_USER_BASE  15

// axi responses
`define DMAP_RESP_OKAY      2'b00
`define DMAP_RESP_DECERR    2'b11

`endif

//--- verilog/dmap_in_route.v
// dmap_in_route: level correction of input pins and routing of pins onto input functions
// purely combinational; the top flops its outputs. pins are taken as synchronous.
`timescale 1ns/10ps
`default_nettype none

module dmap_in_route #(
  parameter N_FUNC = 32,
  parameter N_PIN  = 12,
  parameter N_FIX  = 3,
  parameter SEL_W  = 6,
  parameter LAUNCH = 12
) (
  input  wire [N_PIN-1:0]               pin_in,
  input  wire [N_PIN-1:0]               level_in,
  input  wire [(N_PIN-N_FIX)*SEL_W-1:0] sel_flat_in,
  input  wire [N_FUNC-1:0]              force_in,
  output wire [N_PIN-1:0]               pin_on_out,
  output wire [N_FUNC-1:0]              func_out
);

  genvar p;
  genvar f;

  // high active reads on at 24 v (pin 1), low active at 0 v (pin 0)
  generate
    for (p = 0; p < N_PIN; p = p + 1)
    begin : g_lvl
      assign pin_on_out[p] = level_in[p] ? pin_in[p] : ~pin_in[p];
    end
  endgenerate

  // each function gathers the pins that select it, then its force bit, except the launch function
  generate
    for (f = 0; f < N_FUNC; f = f + 1)
    begin : g_fn
      localparam [SEL_W-1:0] FCODE = f + 1;
      wire [N_PIN-N_FIX-1:0] hit;
      wire                   from_pin;
      for (p = 0; p < N_PIN - N_FIX; p = p + 1)
      begin : g_hit
        // fixed functions cannot be picked by an assignable pin
        if (f < N_FIX)
        begin : g_no
          assign hit[p] = 1'b0;
        end
        else
        begin : g_yes
          assign hit[p] = (sel_flat_in[p*SEL_W +: SEL_W] == FCODE) & pin_on_out[N_FIX+p];
        end
      end
      if (f < N_FIX)
      begin : g_fix
        assign from_pin = pin_on_out[f] | (|hit);
      end
      else
      begin : g_asg
        assign from_pin = |hit;
      end
      // the launch function is reachable only from its pin
      if (f == LAUNCH)
      begin : g_launch
        assign func_out[f] = from_pin;
      end
      else
      begin : g_force
        assign func_out[f] = from_pin | force_in[f];
      end
    end
  endgenerate

endmodule // dmap_in_route

`default_nettype wire

//--- verilog/dmap_out_route.v
// dmap_out_route: routing of output functions onto output pins with level setting
// purely combinational; the top flops the pin levels before they leave the block
`timescale 1ns/10ps
`default_nettype none

module dmap_out_route #(
  parameter N_FUNC = 24,
  parameter N_PIN  = 10,
  parameter N_FIX  = 1,
  parameter SEL_W  = 6
) (
  input  wire [N_FUNC-1:0]              func_in,
  input  wire [N_PIN-1:0]               level_in,
  input  wire [(N_PIN-N_FIX)*SEL_W-1:0] sel_flat_in,
  output wire [N_PIN-1:0]               pin_on_out,
  output wire [N_PIN-1:0]               pin_level_out
);

  genvar p;
  genvar f;

  generate
    for (p = 0; p < N_PIN; p = p + 1)
    begin : g_pin
      if (p < N_FIX)
      begin : g_fix
        // dedicated pins carry their own function only
        assign pin_on_out[p] = func_in[p];
      end
      else
      begin : g_asg
        wire [N_FUNC-1:0] hit;
        for (f = 0; f < N_FUNC; f = f + 1)
        begin : g_hit
          localparam [SEL_W-1:0] FCODE = f + 1;
          if (f < N_FIX)
          begin : g_no
            assign hit[f] = 1'b0;
          end
          else
          begin : g_yes
            assign hit[f] = (sel_flat_in[(p-N_FIX)*SEL_W +: SEL_W] == FCODE) & func_in[f];
          end
        end
        assign pin_on_out[p] = |hit;
      end
      // on drives 0 v when low active, 24 v when high active
      assign pin_level_out[p] = ~(pin_on_out[p] ^ level_in[p]);
    end
  endgenerate

endmodule // dmap_out_route

`default_nettype wire

//--- verif/dmap_assertions.sv
// checker beside dmap_top: axi answers, fixed pins and the save pulse
// assumes the master offers write address and data at the same edge
`timescale 1ns/10ps
`default_nettype none
`include "dmap_consts.vh"

module dmap_chk (
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0]  s_axi_wstrb_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [11:0] in_pin_in,
  input wire logic [23:0] out_func_in,
  input wire logic [31:0] in_func_out,
  input wire logic [9:0]  out_pin_out,
  input wire logic        nv_save_out
);
  logic [1:0]  up;
  logic        pend, lvl_i0, lvl_o0, frc0, nv_req;
  logic [11:0] paddr;
  logic [31:0] pdata;
  logic [3:0]  pstrb;
  wire         wr_hs;

  assign wr_hs = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;

  // shadow of pin 0 settings, applied one edge after the handshake as the design does
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      up <= 2'h0;
      pend <= 1'b0;
      nv_req <= 1'b0;
      lvl_i0 <= 1'b0;
      lvl_o0 <= 1'b0;
      frc0 <= 1'b0;
    end
    else
    begin
      if (up != 2'h2) up <= up + 2'h1; // outputs right after reset still show reset values
      pend <= wr_hs;
      paddr <= s_axi_awaddr_in;
      pdata <= s_axi_wdata_in;
      pstrb <= s_axi_wstrb_in;
      nv_req <= wr_hs && s_axi_awaddr_in == `DMAP_NV_CTRL_ADDR && s_axi_wdata_in[0] && s_axi_wstrb_in[0];
      if (pend && paddr == `DMAP_IN_CFG_BASE && pstrb[1]) lvl_i0 <= pdata[8];
      if (pend && paddr == `DMAP_OUT_CFG_BASE && pstrb[1]) lvl_o0 <= pdata[8];
      if (pend && paddr == `DMAP_FORCE_ADDR && pstrb[0]) frc0 <= pdata[0];
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_write_answer;
    wr_hs |=> !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing two cycles after handshake");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_read_answer;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data missing one cycle after address");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before taken");
  property p_fixed_in;
    up == 2'h2 |-> in_func_out[0] == (($past(in_pin_in[0]) ~^ $past(lvl_i0)) | $past(frc0));
  endproperty
  a_fixed_in: assert property (p_fixed_in)
    else $error("positive limit function does not follow its pin");
  property p_fixed_out;
    up == 2'h2 |-> out_pin_out[0] == !($past(out_func_in[0]) ^ $past(lvl_o0));
  endproperty
  a_fixed_out: assert property (p_fixed_out)
    else $error("compare pin does not follow compare function");
  property p_nv_match;
    nv_save_out == $past(nv_req);
  endproperty
  a_nv_match: assert property (p_nv_match)
    else $error("save pulse not tied to a save write");
  property p_nv_once;
    nv_save_out |=> !nv_save_out;
  endproperty
  a_nv_once: assert property (p_nv_once)
    else $error("save pulse longer than one cycle");

  c_write: cover property (wr_hs);
  c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_save: cover property (nv_save_out);
endmodule // dmap_chk
`default_nettype wire

//--- verif/dmap_wiring_model.sv
// wiring model: sensors and switches on the input pins of the connector
// assumes the bench names the wanted electrical level of every pin
`timescale 1ns/10ps
`default_nettype none

module dmap_wiring_model #(
  parameter int LAG = 1
) (
  input  wire logic        ref_clk_in,
  input  wire logic [11:0] sense_on_in,
  output wire logic [11:0] in_pin_out
);
  logic [11:0] stage [LAG] = '{default: 12'h000};

  // switches settle LAG clocks late, so the mapper sees every pin edge delayed by the same count
  always @(posedge ref_clk_in)
  begin
    stage[0] <= sense_on_in;
    for (int i = 1; i < LAG; i++) stage[i] <= stage[i - 1];
  end
  assign in_pin_out = stage[LAG - 1]; // 1 means 24 v, 0 means 0 v
endmodule // dmap_wiring_model
`default_nettype wire

//--- verif/dmap_tb_top.sv
// testbench of dmap_top: random settings, pins and forces with corner cases
// assumes the wiring model settles pins within two clocks
`timescale 1ns/10ps
`default_nettype none
`include "dmap_consts.vh"

module dmap_tb_top;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [11:0] s_axi_awaddr_in = 12'h000;
  logic [11:0] s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb_in = 4'hf;
  logic        s_axi_awvalid_in = 1'b0;
  logic        s_axi_wvalid_in = 1'b0;
  logic        s_axi_bready_in = 1'b1;
  logic        s_axi_arvalid_in = 1'b0;
  logic        s_axi_rready_in = 1'b1;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, nv_save_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
  logic [31:0] s_axi_rdata_out, in_func_out, frc, d;
  logic [9:0]  out_pin_out, olvl;
  wire  [11:0] in_pin_in;
  logic [23:0] out_func_in = 24'h00_0000;
  logic [11:0] sense = 12'h000;
  logic [11:0] ilvl;
  logic [5:0]  isel [12];
  logic [5:0]  osel [10];
  logic [8:0]  uout, tg;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          nv_seen = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  dmap_top dut (.*);
  dmap_wiring_model #(.LAG(2)) wiring (
    .ref_clk_in  (ref_clk_in),
    .sense_on_in (sense),
    .in_pin_out  (in_pin_in)
  );

  // a plain count shows a missing or doubled save pulse
  always @(posedge ref_clk_in)
  begin
    if (nv_save_out === 1'b1) nv_seen <= nv_seen + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s: saw %h wanted %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hang(input string what);
    n_fail++;
    $display("[ERR] %0t %s timed out", $time, what);
    give_verdict();
  endtask

  // each channel holds until its own ready; response and read ready stay high throughout
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    int n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      n++;
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (n > 40) hang("write");
    end
    while (s_axi_bvalid_out !== 1'b1);
    r = s_axi_bresp_out;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      n++;
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (n > 40) hang("read");
    end
    while (s_axi_rvalid_out !== 1'b1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
  endtask

  task automatic set_in(input int p, input logic [5:0] s, input logic l);
    axi_wr(`DMAP_IN_CFG_BASE + 12'(4 * p), {23'h00_0000, l, 2'b00, s});
    isel[p] = (p < 3) ? 6'(p + 1) : s;
    ilvl[p] = l;
  endtask

  task automatic set_out(input int p, input logic [5:0] s, input logic l);
    axi_wr(`DMAP_OUT_CFG_BASE + 12'(4 * p), {23'h00_0000, l, 2'b00, s});
    osel[p] = (p == 0) ? 6'h01 : s;
    olvl[p] = l;
  endtask

  task automatic do_reset(input int cycles);
    reset_n_in <= 1'b0;
    repeat (cycles) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    frc = '0;
    uout = '0;
    ilvl = '0;
    olvl = '0;
    for (int p = 0; p < 12; p++) isel[p] = (p < 3) ? 6'(p + 1) : 6'h00;
    for (int p = 0; p < 10; p++) osel[p] = (p == 0) ? 6'h01 : 6'h00;
    @(posedge ref_clk_in);
  endtask

  // expected input functions; the launch function ignores forcing
  function automatic logic [31:0] exp_func(input logic [11:0] pins);
    logic [31:0] v;
    logic [11:0] on;
    on = ~(pins ^ ilvl);
    v = frc & 32'hffff_efff;
    for (int p = 0; p < 12; p++)
      if (on[p] && isel[p] != 6'h00 && isel[p] <= 6'h20) v[isel[p] - 6'h01] = 1'b1;
    return v;
  endfunction

  // user outputs take the toggle state in place of the drive's bits
  function automatic logic [9:0] exp_out_on();
    logic [23:0] f;
    logic [9:0]  on;
    f = {uout, out_func_in[14:0]};
    on = '0;
    for (int p = 0; p < 10; p++)
      if (osel[p] != 6'h00 && osel[p] <= 6'h18) on[p] = f[osel[p] - 6'h01];
    return on;
  endfunction

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    hang("run");
  end

  initial
  begin
    void'($urandom(32'heaa0));
    do_reset(8);
    for (int p = 0; p < 12; p++)
    begin
      axi_rd(`DMAP_IN_CFG_BASE + 12'(4 * p));
      check(d, {26'h000_0000, isel[p]}, "input setting after reset");
    end
    for (int p = 0; p < 10; p++)
    begin
      axi_rd(`DMAP_OUT_CFG_BASE + 12'(4 * p));
      check(d, {26'h000_0000, osel[p]}, "output setting after reset");
    end
    axi_rd(12'h0fc);
    check({d[29:0], r}, {30'h0000_0000, `DMAP_RESP_DECERR}, "unmapped read");
    axi_wr(12'h0fc, 32'hffff_ffff);
    check(32'(r), 32'(`DMAP_RESP_DECERR), "unmapped write");
    set_in(0, 6'h3f, 1'b1);
    axi_rd(`DMAP_IN_CFG_BASE);
    check(d, 32'h0000_0101, "fixed input keeps its function");
    set_out(0, 6'h05, 1'b1);
    axi_rd(`DMAP_OUT_CFG_BASE);
    check(d, 32'h0000_0101, "compare pin keeps its function");
    $display("test reset and fixed pins done");
    for (int t = 0; t < 24; t++)
    begin
      set_in(3 + $urandom_range(8), $urandom_range(1) ? 6'(4 + $urandom_range(28)) : 6'h00, 1'($urandom));
      set_out(1 + $urandom_range(8), $urandom_range(3) ? 6'(2 + $urandom_range(22)) : 6'h00, 1'($urandom));
      frc = $urandom;
      axi_wr(`DMAP_FORCE_ADDR, frc);
      check(32'(r), 32'(`DMAP_RESP_OKAY), "mapped write answer");
      tg = 9'($urandom);
      axi_wr(`DMAP_TOGGLE_ADDR, 32'(tg));
      uout = uout ^ tg;
      sense <= 12'($urandom);
      out_func_in <= 24'($urandom);
      repeat (5) @(posedge ref_clk_in);
      check(in_func_out, exp_func(sense), "input functions");
      check(32'(out_pin_out), {22'h00_0000, ~(exp_out_on() ^ olvl)}, "output pins");
      axi_rd(`DMAP_IN_PIN_ADDR);
      check(d, {20'h0_0000, ~(sense ^ ilvl)}, "input pin status");
      axi_rd(`DMAP_OUT_PIN_ADDR);
      check(d, 32'(exp_out_on()), "output pin status");
      axi_rd(`DMAP_USER_OUT_ADDR);
      check(d, 32'(uout), "user output state");
    end
    $display("test random mapping done");
    for (int p = 3; p < 12; p++) set_in(p, 6'h00, 1'b0);
    set_in(5, 6'h0d, 1'b1);
    frc = 32'h0004_1000;
    axi_wr(`DMAP_FORCE_ADDR, frc);
    sense <= 12'h000;
    repeat (5) @(posedge ref_clk_in);
    check(in_func_out, 32'h0004_0006, "pause forced, launch not");
    sense <= 12'h020;
    repeat (5) @(posedge ref_clk_in);
    check(in_func_out, 32'h0004_1006, "launch from its pin");
    axi_rd(`DMAP_FUNC_ADDR);
    check(d, 32'h0004_1006, "function state word");
    axi_wr(`DMAP_NV_CTRL_ADDR, 32'h0000_0001);
    axi_wr(`DMAP_NV_CTRL_ADDR, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_in);
    check(32'(nv_seen), 32'h0000_0001, "one save pulse");
    do_reset(2);
    axi_rd(`DMAP_IN_CFG_BASE + 12'h014);
    check(d, 32'h0000_0000, "setting lost on reset");
    axi_rd(`DMAP_FORCE_ADDR);
    check(d, 32'h0000_0000, "force lost on reset");
    $display("test launch, save and reset done");
    give_verdict();
  end
endmodule // dmap_tb_top

bind dmap_top dmap_chk u_chk (.*);
`default_nettype wire
